// file: rtl/gpio_bank_pkg.sv
/*
 * Shared constants for the change-tracking GPIO bank: register map,
 * reset values, strap address and glitch-filter timing.
 * Assumes a 50 MHz logic clock and a 32-bit AHB-Lite register bus.
 */
package gpio_bank_pkg;

    localparam int PORTS = 4;
    localparam int PINS_PER_PORT = 8;
    localparam int PINS = PORTS * PINS_PER_PORT;

    ////////////////////////////////////////////////////////////////////////
    // Register map (byte offsets, one word each)
    localparam logic [7:0] OFS_DIR = 8'h00;
    localparam logic [7:0] OFS_OTYPE = 8'h04;
    localparam logic [7:0] OFS_MASK = 8'h08;
    localparam logic [7:0] OFS_STATUS = 8'h0c;
    localparam logic [7:0] OFS_DATA0 = 8'h10;
    localparam logic [7:0] OFS_DATA_STEP = 8'h04;
    localparam logic [7:0] OFS_ADDR = 8'h20;

    localparam logic [31:0] DIR_RST = 32'h0000_0000;
    localparam logic [31:0] OTYPE_RST = 32'h0000_0000;
    localparam logic [31:0] MASK_RST = 32'h0000_0000;
    localparam logic [31:0] OUT_RST = 32'h0000_0000;
    localparam logic [3:0] STATUS_RST = 4'h0;

    ////////////////////////////////////////////////////////////////////////
    // Bus encodings
    localparam logic [2:0] HSIZE_WORD = 3'h2;

    ////////////////////////////////////////////////////////////////////////
    // Slave address: fixed upper six bits, strap gives the lowest
    localparam logic [5:0] SLAVE_ADDR_HI = 6'h12;
    localparam logic [1:0] STRAP_WAIT = 2'h2;

    ////////////////////////////////////////////////////////////////////////
    // Glitch filter timing
    localparam int CLK_PERIOD_NS = 20;
    localparam int GLITCH_MIN_NS = 15;
    localparam int GLITCH_TYP_NS = 40;
    localparam int GLITCH_MAX_NS = 100;
    localparam int REJECT_CYC = (GLITCH_MIN_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    localparam int ACCEPT_CYC = GLITCH_MAX_NS / CLK_PERIOD_NS;
    localparam int FILT_CYC = (GLITCH_TYP_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;

endpackage : gpio_bank_pkg

// file: rtl/pin_filter.sv
/*
 * One pin input: two-flop synchroniser followed by a stability filter.
 * Assumes pin_raw is asynchronous to ref_clk.
 */
`timescale 1ns/1ps
module pin_filter
    import gpio_bank_pkg::*;
#(
    parameter int STABLE_CYC = FILT_CYC
) (
    input wire logic ref_clk,       // Logic clock
    input wire logic reset_n,       // Async reset, active low
    input wire logic pin_raw,       // Raw pin level
    output logic level,             // Filtered level
    output logic level_valid        // First stable level taken
);

    localparam int CW = $clog2(STABLE_CYC + 1);
    localparam logic [CW-1:0] LAST = CW'(STABLE_CYC - 1);

    logic sync1_r, sync2_r;
    logic [1:0] fill_r, fill_nxt;
    logic level_r, level_nxt;
    logic valid_r, valid_nxt;
    logic [CW-1:0] cnt_r, cnt_nxt;

    ////////////////////////////////////////////////////////////////////////
    // Pulses shorter than STABLE_CYC samples never reach the output
    always_comb begin
        level_nxt = level_r;
        valid_nxt = valid_r;
        cnt_nxt = '0;
        fill_nxt = {fill_r[0], 1'b1};
        // Reset zeros in the synchroniser must not become a first level
        if (fill_r[1] && (!valid_r || sync2_r != level_r)) begin
            if (cnt_r == LAST) begin
                level_nxt = sync2_r;
                valid_nxt = 1'b1;
            end else begin
                cnt_nxt = cnt_r + 1'b1;
            end
        end
    end

    always_ff @(posedge ref_clk or negedge reset_n) begin
        if (!reset_n) begin
            sync1_r <= 1'b0;
            sync2_r <= 1'b0;
            fill_r <= 2'h0;
            level_r <= 1'b0;
            valid_r <= 1'b0;
            cnt_r <= '0;
        end else begin
            sync1_r <= pin_raw;
            sync2_r <= sync1_r;
            fill_r <= fill_nxt;
            level_r <= level_nxt;
            valid_r <= valid_nxt;
            cnt_r <= cnt_nxt;
        end
    end

    assign level = level_r;
    assign level_valid = valid_r;

    ////////////////////////////////////////////////////////////////////////
    default clocking cb @(posedge ref_clk); endclocking
    default disable iff (!reset_n);

    a_filter_stable: assert property (
        (valid_r && $changed(level_r)) |->
            ($past(sync2_r) == level_r && $past(sync2_r, 2) == level_r))
        else $error("filtered level changed without a stable input");

endmodule : pin_filter

// file: rtl/gpio_change_bank.sv
/*
 * Thirty-two pin GPIO bank in four ports of eight, with per-port change
 * status and an active-low open-drain event output, on an AHB-Lite slave.
 * Assumes one AHB-Lite master, word transfers, and asynchronous pins.
 */
// What this block does
// - After reset every one of the 32 pins is an input.
// - One direction bit per pin: zero input, one output.
// - One output-type bit per pin selects push-pull or open-drain.
// - Reading an input pin's data bit returns its filtered level.
// - A push-pull output pin drives its data bit; an open-drain one drives only a zero.
// - Data written to an input pin is held, appears when switched to output.
// - Data register writes never set change status or the event output.
// - Rising and falling edges on unmasked input pins are both events.
// - One change bit per port, set by unmasked input changes since last read.
// - Mask one suppresses events but data still tracks; mask zero enables.
// - Changing a mask bit alone never touches status or the event output.
// - No pin change is lost, even during a data register read.
// - Repeated toggles keep data tracking while status and event stay set.
// - A port's change bit clears at start of its data read.
// - Event output low while any change bit set, high when all clear.
// - Output-mode pins never update input data, status or event output.
// - Inputs pass a glitch filter: reject under 15ns, accept by 100ns.
// - Slave address is fixed upper bits plus a strap sampled after reset.
`timescale 1ns/1ps
module gpio_change_bank
    import gpio_bank_pkg::*;
(
    input wire logic ref_clk,                // 50 MHz logic clock
    input wire logic reset_n,                // Async reset, active low
    input wire logic hsel,                   // AHB select
    input wire logic [31:0] haddr,           // AHB address
    input wire logic [1:0] htrans,           // AHB transfer type
    input wire logic hwrite,                 // AHB write
    input wire logic [2:0] hsize,            // AHB size
    input wire logic [31:0] hwdata,          // AHB write data
    input wire logic hready,                 // AHB bus ready
    output logic hreadyout,                  // AHB slave ready
    output logic [31:0] hrdata,              // AHB read data
    output logic hresp,                      // AHB response, always OKAY
    input wire logic [PINS-1:0] port_pin_i,  // Pin levels in
    output logic [PINS-1:0] port_pin_o,      // Pin levels out
    output logic [PINS-1:0] port_pin_oe,     // Pin drive enables
    input wire logic slave_addr_select_pin,  // Address strap
    output logic gpio_event_irq_n_o,         // Event pin level when driven
    output logic gpio_event_irq_n_oe         // Event pin pulled low
);

    ////////////////////////////////////////////////////////////////////////
    // Helpers
    function automatic logic [7:0] data_ofs(input int p);
        data_ofs = OFS_DATA0 + 8'(p) * OFS_DATA_STEP;
    endfunction : data_ofs

    ////////////////////////////////////////////////////////////////////////
    // Pin filters
    logic [PINS-1:0] lvl, lvl_ok;

    for (genvar i = 0; i < PINS; i++) begin : g_pin
        pin_filter #(.STABLE_CYC(FILT_CYC)) u_filt (
            .ref_clk(ref_clk),
            .reset_n(reset_n),
            .pin_raw(port_pin_i[i]),
            .level(lvl[i]),
            .level_valid(lvl_ok[i])
        );
    end

    ////////////////////////////////////////////////////////////////////////
    // State
    logic [PINS-1:0] dir_r, dir_nxt;
    logic [PINS-1:0] otype_r, otype_nxt;
    logic [PINS-1:0] mask_r, mask_nxt;
    logic [PINS-1:0] out_r, out_nxt;
    logic [PINS-1:0] in_data_r, in_data_nxt;
    logic [PINS-1:0] prev_lvl_r, prev_ok_r;
    logic [PORTS-1:0] status_r, status_nxt;
    logic [PINS-1:0] pin_o_r, pin_o_nxt, pin_oe_r, pin_oe_nxt;
    logic irq_oe_r, irq_oe_nxt;
    logic wr_pend_r, wr_pend_nxt;
    logic [7:0] wr_addr_r, wr_addr_nxt;
    logic [31:0] hrdata_r, hrdata_nxt;
    logic strap_s1_r, strap_s2_r;
    logic [1:0] strap_cnt_r, strap_cnt_nxt;
    logic [6:0] slave_addr_r, slave_addr_nxt;

    logic [PINS-1:0] evt;
    logic [PORTS-1:0] set_vec, rd_clr_vec;
    logic take, rd_take;
    logic [31:0] rd_val;

    ////////////////////////////////////////////////////////////////////////
    // Address phase decode; data-phase writes land one cycle later
    always_comb begin
        take = hsel && hready && htrans[1] && hsize == HSIZE_WORD;
        rd_take = take && !hwrite;
        wr_pend_nxt = take && hwrite;
        wr_addr_nxt = haddr[7:0];
        for (int p = 0; p < PORTS; p++) begin
            rd_clr_vec[p] = rd_take && haddr[7:0] == data_ofs(p);
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Configuration and output latch
    always_comb begin
        dir_nxt = dir_r;
        otype_nxt = otype_r;
        mask_nxt = mask_r;
        out_nxt = out_r;
        if (wr_pend_r) begin
            unique case (wr_addr_r)
                OFS_DIR: dir_nxt = hwdata;
                OFS_OTYPE: otype_nxt = hwdata;
                OFS_MASK: mask_nxt = hwdata;
                default: begin
                    for (int p = 0; p < PORTS; p++) begin
                        if (wr_addr_r == data_ofs(p)) begin
                            out_nxt[p*8 +: 8] = hwdata[7:0];
                        end
                    end
                end
            endcase
        end
        // Open-drain pins drive only low; a one releases the wire
        pin_o_nxt = out_nxt & ~otype_nxt;
        pin_oe_nxt = dir_nxt & (~otype_nxt | ~out_nxt);
    end

    always_ff @(posedge ref_clk or negedge reset_n) begin
        if (!reset_n) begin
            dir_r <= DIR_RST;
            otype_r <= OTYPE_RST;
            mask_r <= MASK_RST;
            out_r <= OUT_RST;
            pin_o_r <= '0;
            pin_oe_r <= '0;
            wr_pend_r <= 1'b0;
            wr_addr_r <= 8'h00;
        end else begin
            dir_r <= dir_nxt;
            otype_r <= otype_nxt;
            mask_r <= mask_nxt;
            out_r <= out_nxt;
            pin_o_r <= pin_o_nxt;
            pin_oe_r <= pin_oe_nxt;
            wr_pend_r <= wr_pend_nxt;
            wr_addr_r <= wr_addr_nxt;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Input data, change detection, status and event output
    always_comb begin
        evt = lvl_ok & prev_ok_r & (lvl ^ prev_lvl_r);
        for (int p = 0; p < PORTS; p++) begin
            set_vec[p] = |(evt[p*8 +: 8] & ~dir_r[p*8 +: 8] & ~mask_r[p*8 +: 8]);
        end
        // Only input pins follow the filtered level
        in_data_nxt = (in_data_r & (dir_r | ~lvl_ok)) | (lvl & ~dir_r & lvl_ok);
        // Set wins so a change during the read survives it
        status_nxt = (status_r & ~rd_clr_vec) | set_vec;
        irq_oe_nxt = |status_nxt;
    end

    always_ff @(posedge ref_clk or negedge reset_n) begin
        if (!reset_n) begin
            in_data_r <= '0;
            prev_lvl_r <= '0;
            prev_ok_r <= '0;
            status_r <= STATUS_RST;
            irq_oe_r <= 1'b0;
        end else begin
            in_data_r <= in_data_nxt;
            prev_lvl_r <= lvl;
            prev_ok_r <= lvl_ok;
            status_r <= status_nxt;
            irq_oe_r <= irq_oe_nxt;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Read data, taken from next-state values so a write just before shows
    always_comb begin
        rd_val = 32'h0000_0000;
        unique case (haddr[7:0])
            OFS_DIR: rd_val = dir_nxt;
            OFS_OTYPE: rd_val = otype_nxt;
            OFS_MASK: rd_val = mask_nxt;
            OFS_STATUS: rd_val = {28'h0000_000, status_r};
            OFS_ADDR: rd_val = {25'h0, slave_addr_r};
            default: begin
                for (int p = 0; p < PORTS; p++) begin
                    if (haddr[7:0] == data_ofs(p)) begin
                        rd_val[7:0] = (out_nxt[p*8 +: 8] & dir_nxt[p*8 +: 8])
                            | (in_data_nxt[p*8 +: 8] & ~dir_nxt[p*8 +: 8]);
                    end
                end
            end
        endcase
        hrdata_nxt = rd_take ? rd_val : hrdata_r;
    end

    always_ff @(posedge ref_clk or negedge reset_n) begin
        if (!reset_n) begin
            hrdata_r <= 32'h0000_0000;
        end else begin
            hrdata_r <= hrdata_nxt;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Address strap, sampled once after reset release
    always_comb begin
        strap_cnt_nxt = strap_cnt_r;
        slave_addr_nxt = slave_addr_r;
        // The second flop holds the pin only from the second edge on
        if (strap_cnt_r <= STRAP_WAIT) begin
            strap_cnt_nxt = strap_cnt_r + 2'h1;
            if (strap_cnt_r == STRAP_WAIT) begin
                slave_addr_nxt = {SLAVE_ADDR_HI, strap_s2_r};
            end
        end
    end

    always_ff @(posedge ref_clk or negedge reset_n) begin
        if (!reset_n) begin
            strap_s1_r <= 1'b0;
            strap_s2_r <= 1'b0;
            strap_cnt_r <= 2'h0;
            slave_addr_r <= {SLAVE_ADDR_HI, 1'b0};
        end else begin
            strap_s1_r <= slave_addr_select_pin;
            strap_s2_r <= strap_s1_r;
            strap_cnt_r <= strap_cnt_nxt;
            slave_addr_r <= slave_addr_nxt;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Outputs; zero wait states, so hreadyout and hresp are constant flops
    logic ready_r, resp_r;

    always_ff @(posedge ref_clk or negedge reset_n) begin
        if (!reset_n) begin
            ready_r <= 1'b1;
            resp_r <= 1'b0;
        end else begin
            ready_r <= 1'b1;
            resp_r <= 1'b0;
        end
    end

    assign hreadyout = ready_r;
    assign hresp = resp_r;
    assign hrdata = hrdata_r;
    assign port_pin_o = pin_o_r;
    assign port_pin_oe = pin_oe_r;
    assign gpio_event_irq_n_o = resp_r;
    assign gpio_event_irq_n_oe = irq_oe_r;

    ////////////////////////////////////////////////////////////////////////
    // Checks
    logic dir_written_r;

    always_ff @(posedge ref_clk or negedge reset_n) begin
        if (!reset_n) begin
            dir_written_r <= 1'b0;
        end else if (wr_pend_r && wr_addr_r == OFS_DIR) begin
            dir_written_r <= 1'b1;
        end
    end

    default clocking cb @(posedge ref_clk); endclocking
    default disable iff (!reset_n);

    sequence s_port_read;
        (rd_clr_vec != 4'h0) && ((rd_clr_vec & set_vec) == 4'h0);
    endsequence

    sequence s_port_event;
        set_vec != 4'h0;
    endsequence

    a_reset_inputs: assert property (!dir_written_r |-> (dir_r == '0 && port_pin_oe == '0))
        else $error("pin driven before direction was written");

    a_dir_gates_oe: assert property ((port_pin_oe & ~dir_r) == '0)
        else $error("input pin is being driven");

    a_od_no_high: assert property ((port_pin_o & otype_r) == '0)
        else $error("open-drain pin drives high");

    a_pp_follows: assert property (((port_pin_o ^ out_r) & dir_r & ~otype_r) == '0)
        else $error("push-pull pin does not follow latch");

    a_event_sets: assert property (
        s_port_event |=> ((status_r & $past(set_vec)) == $past(set_vec)))
        else $error("change event not latched");

    a_no_cause_set: assert property (
        ((status_r & ~$past(status_r)) & ~$past(set_vec)) == 4'h0)
        else $error("change bit set without an event");

    a_read_clears: assert property (
        s_port_read |=> ((status_r & $past(rd_clr_vec)) == 4'h0) [*1])
        else $error("data read did not clear change bit");

    a_irq_level: assert property (irq_oe_r == (status_r != 4'h0))
        else $error("event output disagrees with change bits");

    a_out_no_track: assert property (
        (dir_r != '0) |=> ((((in_data_r ^ $past(in_data_r)) & $past(dir_r)) == '0)))
        else $error("output pin updated input data");

    a_addr_fixed: assert property (slave_addr_r[6:1] == SLAVE_ADDR_HI)
        else $error("slave address upper bits wrong");

endmodule : gpio_change_bank

// file: dv/pin_env.sv
/*
 * Board model of the pin side: resolves each GPIO wire and the event line.
 * Assumes external drivers stay weak wherever the bank drives a pin.
 */
`timescale 1ns/1ps
module pin_env
    import gpio_bank_pkg::*;
(
    input wire logic [PINS-1:0] ext_drv,    // Level forced by the board
    input wire logic [PINS-1:0] pin_o,      // Bank drive level
    input wire logic [PINS-1:0] pin_oe,     // Bank drive enable
    input wire logic irq_o,                 // Event drive level
    input wire logic irq_oe,                // Event drive enable
    output logic [PINS-1:0] pin_level,      // Resolved pin wires
    output logic irq_line_n                 // Resolved event wire
);
    ////////////////////////////////////////////////////////////////////////
    // Bank wins where it drives; board level elsewhere
    always_comb begin
        for (int i = 0; i < PINS; i++) begin
            pin_level[i] = pin_oe[i] ? pin_o[i] : ext_drv[i];
        end
    end

    // Pull-up holds the open-drain event line high when released
    assign irq_line_n = irq_oe ? irq_o : 1'b1;
endmodule : pin_env

// file: dv/smbus_gpio_change_irq_test.sv
/*
 * Self-checking bench for the change-tracking GPIO bank over AHB-Lite.
 * Assumes zero-wait slave and about five cycles from pin to status.
 */
`timescale 1ns/1ps
module smbus_gpio_change_irq_test
    import gpio_bank_pkg::*;
;
    logic ref_clk = 1'b0;
    logic reset_n = 1'b0;
    logic hsel = 1'b0;
    logic [31:0] haddr = 32'h0;
    logic [1:0] htrans = 2'h0;
    logic hwrite = 1'b0;
    logic [2:0] hsize = HSIZE_WORD;
    logic [31:0] hwdata = 32'h0;
    logic hreadyout, hresp, irq_o, irq_oe, irq_line_n;
    logic [31:0] hrdata, rd_val;
    logic [PINS-1:0] drv = '0;
    logic strap = 1'b1;
    logic [PINS-1:0] pin_level, pin_o, pin_oe;
    int n_fail = 0;
    int cmp_count = 0;

    always #10 ref_clk = ~ref_clk;

    gpio_change_bank dut_u (.ref_clk(ref_clk), .reset_n(reset_n), .hsel(hsel),
        .haddr(haddr), .htrans(htrans), .hwrite(hwrite), .hsize(hsize),
        .hwdata(hwdata), .hready(hreadyout), .hreadyout(hreadyout), .hrdata(hrdata),
        .hresp(hresp), .port_pin_i(pin_level), .port_pin_o(pin_o),
        .port_pin_oe(pin_oe), .slave_addr_select_pin(strap),
        .gpio_event_irq_n_o(irq_o), .gpio_event_irq_n_oe(irq_oe));

    pin_env env_u (.ext_drv(drv), .pin_o(pin_o), .pin_oe(pin_oe), .irq_o(irq_o),
        .irq_oe(irq_oe), .pin_level(pin_level), .irq_line_n(irq_line_n));

    ////////////////////////////////////////////////////////////////////////
    task print_verdict();
        $display("compares %0d mismatches %0d", cmp_count, n_fail);
        if (n_fail == 0 && cmp_count > 0) begin
            $display("bench passed");
        end else begin
            $display("bench failed");
        end
        $finish;
    endtask : print_verdict

    task chk(input logic [31:0] got, input logic [31:0] exp);
        cmp_count++;
        if (got !== exp) begin
            n_fail++;
            $display("CHECK FAILED at %0t got %h exp %h", $time, got, exp);
        end
    endtask : chk

    // Bounded wait for hready at a rising edge
    task wait_ready();
        int i;
        for (i = 0; i < 50; i++) begin
            @(posedge ref_clk);
            if (hreadyout === 1'b1) break;
        end
        if (i == 50) begin
            n_fail++;
            print_verdict();
        end
    endtask : wait_ready

    task bus(input logic wr, input logic [7:0] addr, input logic [31:0] wd);
        hsel <= 1'b1;
        haddr <= {24'h0, addr};
        htrans <= 2'h2;
        hwrite <= wr;
        hsize <= HSIZE_WORD;
        wait_ready();
        htrans <= 2'h0;
        hwdata <= wd;
        wait_ready();
        rd_val = hrdata;
    endtask : bus

    task rd(input logic [7:0] addr, input logic [31:0] exp);
        bus(1'b0, addr, 32'h0);
        chk(rd_val, exp);
    endtask : rd

    task settle(input int n);
        repeat (n) @(posedge ref_clk);
        #1;
    endtask : settle

    ////////////////////////////////////////////////////////////////////////
    initial begin
        repeat (3) @(posedge ref_clk);
        reset_n <= 1'b1;
        settle(10);
        rd(OFS_DIR, DIR_RST);
        rd(OFS_OTYPE, OTYPE_RST);
        rd(OFS_MASK, MASK_RST);
        rd(OFS_STATUS, 32'h0);
        chk(pin_oe, 32'h0);
        chk({31'h0, irq_line_n}, 32'h1);
        rd(OFS_ADDR, {25'h0, SLAVE_ADDR_HI, 1'b1});
        rd(8'h24, 32'h0);
        bus(1'b1, 8'h24, 32'hffff_ffff);
        rd(OFS_DIR, DIR_RST);
        // Edges on every port, then drain port by port
        drv <= 32'h8421_c3a5;
        settle(8);
        rd(OFS_STATUS, 32'hf);
        chk({31'h0, irq_line_n}, 32'h0);
        for (int p = 0; p < 4; p++) begin
            rd(OFS_DATA0 + 8'(4 * p), {24'h0, drv[8*p +: 8]});
            rd(OFS_STATUS, 32'hf & (32'hf << (p + 1)));
        end
        chk({31'h0, irq_line_n}, 32'h1);
        // Falling edge, then five toggles 80 ns apart on one pin
        drv[15] <= 1'b0;
        settle(8);
        rd(OFS_STATUS, 32'h2);
        rd(OFS_DATA0 + 8'h04, 32'h43);
        for (int k = 0; k < 5; k++) begin
            drv[15] <= ~drv[15];
            settle(4);
        end
        settle(4);
        rd(OFS_STATUS, 32'h2);
        chk({31'h0, irq_line_n}, 32'h0);
        rd(OFS_DATA0 + 8'h04, 32'hc3);
        // Mask port 0 pins
        bus(1'b1, OFS_MASK, 32'h0000_00ff);
        rd(OFS_STATUS, 32'h0);
        drv[7:0] <= 8'h5a;
        settle(8);
        rd(OFS_STATUS, 32'h0);
        rd(OFS_DATA0, 32'h5a);
        bus(1'b1, OFS_MASK, 32'h0);
        rd(OFS_STATUS, 32'h0);
        chk({31'h0, irq_line_n}, 32'h1);
        // Data write while input, then switch to output
        bus(1'b1, OFS_DATA0 + 8'h08, 32'ha5);
        settle(4);
        rd(OFS_STATUS, 32'h0);
        rd(OFS_DATA0 + 8'h08, 32'h21);
        bus(1'b1, OFS_DIR, 32'h00ff_0000);
        settle(1);
        chk(pin_oe, 32'h00ff_0000);
        chk({24'h0, pin_o[23:16]}, 32'ha5);
        drv[23:16] <= 8'hff;
        settle(8);
        rd(OFS_STATUS, 32'h0);
        rd(OFS_DATA0 + 8'h08, 32'ha5);
        bus(1'b1, OFS_DATA0 + 8'h08, 32'h3c);
        settle(1);
        chk({24'h0, pin_o[23:16]}, 32'h3c);
        rd(OFS_STATUS, 32'h0);
        bus(1'b1, OFS_OTYPE, 32'h00ff_0000);
        settle(1);
        chk({24'h0, pin_oe[23:16]}, 32'hc3);
        bus(1'b1, OFS_DIR, 32'h0);
        settle(8);
        bus(1'b0, OFS_DATA0 + 8'h08, 32'h0);
        // One-cycle glitch is dropped, three-cycle pulse is seen
        drv[24] <= 1'b1;
        @(posedge ref_clk);
        drv[24] <= 1'b0;
        settle(8);
        rd(OFS_STATUS, 32'h0);
        drv[24] <= 1'b1;
        repeat (3) @(posedge ref_clk);
        drv[24] <= 1'b0;
        settle(8);
        rd(OFS_STATUS, 32'h8);
        rd(OFS_DATA0 + 8'h0c, 32'h84);
        // Change still in flight while its port is read
        drv[0] <= ~drv[0];
        @(posedge ref_clk);
        bus(1'b0, OFS_DATA0, 32'h0);
        settle(8);
        rd(OFS_STATUS, 32'h1);
        chk({31'h0, hresp}, 32'h0);
        // Second power-on with port 2 pins high and the strap low
        strap <= 1'b0;
        reset_n <= 1'b0;
        repeat (3) @(posedge ref_clk);
        reset_n <= 1'b1;
        settle(10);
        rd(OFS_STATUS, 32'h0);
        chk(pin_oe, 32'h0);
        rd(OFS_ADDR, {25'h0, SLAVE_ADDR_HI, 1'b0});
        rd(OFS_DATA0 + 8'h08, 32'hff);
        print_verdict();
    end
endmodule : smbus_gpio_change_irq_test
